// file: nibble_alu_pkg.sv
// Constants, encodings and state codes for the nibble ALU
package nibble_alu_pkg;
  // Function
  // - Decimal mode flag set makes every add and subtract decimal, else binary.
  // - Decimal add sums 0..9 give no carry; 10..19 give carry and sum minus ten.
  // - Decimal add sums 20..31 set carry and give the fixed codes of ten or more.
  // - Decimal subtract 0..9 gives no borrow; -10..-1 borrows and adds ten.
  // - Decimal differences 10..15 and -16..-11 borrow and give fixed codes 12..15.
  // - Binary carry set when result leaves 0..15; stored nibble is low four bits.
  // - Compare-only flag clear: arithmetic result written to first operand location.
  // - Compare-only clear: zero flag follows stored nibble equal zero, ignoring carry.
  // - First operand latched into temp A, second into temp B, before computing.
  // - First operand from register or memory; second from memory or immediate.
  // - Rotate right through carry uses only the first operand, loads no second.
  // - Arithmetic with compare-only clear, logical, rotate write result to first operand location, then end.
  // - Bit and compare evaluations write nothing and output a skip decision.
  // - Logical operations ignore compare-only and decimal flags, keep carry and zero.
  // - Any bit evaluation clears the compare-only flag.
  // - Compare-only and decimal flags come from the status word flip-flops.
  // - Add, add with carry, subtract, subtract with borrow in two operand forms.
  // - With-carry and with-borrow forms use the carry flag as lowest carry in.
  // - Compare-only set: arithmetic result not written, carry and zero still updated.
  // - Compare-only set: zero result keeps zero flag, nonzero result clears it.
  // - Rotate puts old carry in bit 3 and bit 0 into the carry flag.

  // ==========================================
  // Widths
  localparam int NIB_W = 4;
  localparam int OPC_W = 4;
  localparam int ADDR_W = 7;
  localparam int PSW_W = 4;

  // ==========================================
  // Status word field positions
  localparam int PSW_Z = 0;
  localparam int PSW_CY = 1;
  localparam int PSW_CMP = 2;
  localparam int PSW_BCD = 3;
  localparam logic [PSW_W-1:0] PSW_RST = 4'h0;

  // ==========================================
  // Instruction class codes
  localparam logic [OPC_W-1:0] OPC_ADD = 4'h0;
  localparam logic [OPC_W-1:0] OPC_SUM_WITHCARRY = 4'h1;
  localparam logic [OPC_W-1:0] OPC_SUB = 4'h2;
  localparam logic [OPC_W-1:0] OPC_DIFF_WITHBORROW = 4'h3;
  localparam logic [OPC_W-1:0] OPC_OR = 4'h4;
  localparam logic [OPC_W-1:0] OPC_AND = 4'h5;
  localparam logic [OPC_W-1:0] OPC_XOR = 4'h6;
  localparam logic [OPC_W-1:0] OPC_SKT = 4'h7;
  localparam logic [OPC_W-1:0] OPC_SKF = 4'h8;
  localparam logic [OPC_W-1:0] OPC_SKE = 4'h9;
  localparam logic [OPC_W-1:0] OPC_SKNE = 4'ha;
  localparam logic [OPC_W-1:0] OPC_ROTATE_RIGHT_THRU_CARRY = 4'hb;

  // ==========================================
  // Decimal correction figures
  localparam logic [4:0] DEC_NINE = 5'h09;
  localparam logic [4:0] DEC_TEN = 5'h0a;
  localparam logic [4:0] DEC_TWENTY = 5'h14;
  localparam logic [4:0] DEC_HIGH = 5'h1c;
  localparam logic [4:0] DEC_HIGH_OFS = 5'h12;
  localparam logic [4:0] DEC_NEG_TEN = 5'h16;
  localparam logic [1:0] DEC_WRAP_ADJ = 2'h2;
  localparam logic [1:0] DEC_WRAP_TOP = 2'h3;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

  // ==========================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } alu_state_t;
endpackage : nibble_alu_pkg

// file: nibble_alu_bcd_binary.sv
// Nibble ALU with binary and decimal arithmetic, logic, rotate and skip evaluation
`timescale 1ns/1ns
module nibble_alu_bcd_binary (
  input wire logic CLK_SYS, // Core clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic START, // One-cycle request, operands valid
  input wire logic [nibble_alu_pkg::OPC_W-1:0] OPCODE, // Instruction class
  input wire logic USE_IMM, // Second operand is the immediate nibble
  input wire logic [nibble_alu_pkg::ADDR_W-1:0] FIRST_ADDR, // First operand location
  input wire logic [nibble_alu_pkg::NIB_W-1:0] FIRST_DATA, // First operand value
  input wire logic [nibble_alu_pkg::NIB_W-1:0] MEM_DATA, // Memory second operand
  input wire logic [nibble_alu_pkg::NIB_W-1:0] IMM_NIBBLE, // Instruction immediate field
  input wire logic PSW_WR, // Direct status word write
  input wire logic [nibble_alu_pkg::PSW_W-1:0] PSW_WDATA, // Status word write value
  output logic BUSY, // Operation in progress
  output logic DONE, // One-cycle end of operation
  output logic WR_EN, // One-cycle result write strobe
  output logic [nibble_alu_pkg::ADDR_W-1:0] WR_ADDR, // Result location
  output logic [nibble_alu_pkg::NIB_W-1:0] WR_DATA, // Result nibble
  output logic SKIP, // One-cycle skip of next instruction
  output logic [nibble_alu_pkg::PSW_W-1:0] PSW_OUT // Status word mirror
);
  import nibble_alu_pkg::*;

  // ==========================================
  // State and storage
  alu_state_t state_r;
  alu_state_t state_nxt;
  logic [OPC_W-1:0] opc_r;
  logic [NIB_W-1:0] tmp_a_r;
  logic [NIB_W-1:0] tmp_b_r;
  logic [ADDR_W-1:0] addr_r;
  logic z_r;
  logic cy_r;
  logic cmp_r;
  logic bcd_r;
  logic busy_r;
  logic done_r;
  logic wr_en_r;
  logic [NIB_W-1:0] wr_data_r;
  logic skip_r;

  // Decoded classes and results
  logic is_exec;
  logic is_arith;
  logic is_sub;
  logic is_logic;
  logic is_bit;
  logic is_cmpe;
  logic is_rot;
  logic cin;
  logic [4:0] bin_sum;
  logic [4:0] bin_diff;
  logic [4:0] bin_res;
  logic [4:0] dec_res;
  logic [4:0] ar_res;
  logic [NIB_W-1:0] log_res;
  logic skip_nxt;

  // ==========================================
  // Decimal correction of a binary sum
  function automatic logic [4:0] dec_add_fix(input logic [4:0] s);
    logic [4:0] t;
    t = 5'h00;
    if (s <= DEC_NINE) begin
      t = s;
    end else if (s < DEC_TWENTY) begin
      t = {1'b1, 4'(s - DEC_TEN)};
    end else if (s < DEC_HIGH) begin
      t = {1'b1, DEC_WRAP_TOP, 2'(s[1:0] + DEC_WRAP_ADJ)};
    end else begin
      t = {1'b1, 4'(s - DEC_HIGH_OFS)};
    end
    return t;
  endfunction : dec_add_fix

  // Decimal correction of a two's complement difference
  function automatic logic [4:0] dec_sub_fix(input logic [4:0] d);
    logic [4:0] t;
    t = 5'h00;
    if (!d[4] && d <= DEC_NINE) begin
      t = d;
    end else if (d[4] && d >= DEC_NEG_TEN) begin
      t = {1'b1, 4'(d + DEC_TEN)};
    end else begin
      t = {1'b1, DEC_WRAP_TOP, 2'(d[1:0] + DEC_WRAP_ADJ)};
    end
    return t;
  endfunction : dec_sub_fix

  // ==========================================
  // Instruction class decode
  assign is_exec = (state_r == ST_EXEC);
  assign is_arith = (opc_r == OPC_ADD) || (opc_r == OPC_SUM_WITHCARRY) ||
                    (opc_r == OPC_SUB) || (opc_r == OPC_DIFF_WITHBORROW);
  assign is_sub = (opc_r == OPC_SUB) || (opc_r == OPC_DIFF_WITHBORROW);
  assign is_logic = (opc_r == OPC_OR) || (opc_r == OPC_AND) || (opc_r == OPC_XOR);
  assign is_bit = (opc_r == OPC_SKT) || (opc_r == OPC_SKF);
  assign is_cmpe = (opc_r == OPC_SKE) || (opc_r == OPC_SKNE);
  assign is_rot = (opc_r == OPC_ROTATE_RIGHT_THRU_CARRY);

  // ==========================================
  // Arithmetic datapath
  // carry flag as lowest carry or borrow in
  assign cin = ((opc_r == OPC_SUM_WITHCARRY) || (opc_r == OPC_DIFF_WITHBORROW)) ? cy_r : 1'b0;
  assign bin_sum = {1'b0, tmp_a_r} + {1'b0, tmp_b_r} + {4'h0, cin};
  assign bin_diff = {1'b0, tmp_a_r} - {1'b0, tmp_b_r} - {4'h0, cin};
  // binary carry is bit four of the result
  assign bin_res = is_sub ? bin_diff : bin_sum;
  assign dec_res = is_sub ? dec_sub_fix(bin_diff) : dec_add_fix(bin_sum);
  assign ar_res = bcd_r ? dec_res : bin_res;

  // Logical results and skip decisions
  always_comb begin
    log_res = tmp_a_r | tmp_b_r;
    skip_nxt = 1'b0;
    unique case (opc_r)
      OPC_AND: log_res = tmp_a_r & tmp_b_r;
      OPC_XOR: log_res = tmp_a_r ^ tmp_b_r;
      OPC_SKT: skip_nxt = ((tmp_a_r & tmp_b_r) == tmp_b_r);
      OPC_SKF: skip_nxt = ((tmp_a_r & tmp_b_r) == NIB_ZERO);
      OPC_SKE: skip_nxt = (tmp_a_r == tmp_b_r);
      OPC_SKNE: skip_nxt = (tmp_a_r != tmp_b_r);
      default: log_res = tmp_a_r | tmp_b_r;
    endcase
  end

  // ==========================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (START) state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // Operand latch
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      opc_r <= OPC_ADD;
      tmp_a_r <= NIB_ZERO;
      tmp_b_r <= NIB_ZERO;
      addr_r <= '0;
    end else if (START && state_r == ST_IDLE) begin
      opc_r <= OPCODE;
      addr_r <= FIRST_ADDR;
      tmp_a_r <= FIRST_DATA;
      if (OPCODE != OPC_ROTATE_RIGHT_THRU_CARRY) begin
        tmp_b_r <= USE_IMM ? IMM_NIBBLE : MEM_DATA;
      end
    end
  end

  // ==========================================
  // Status flags; hardware update wins over a direct write
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      z_r <= PSW_RST[PSW_Z];
      cy_r <= PSW_RST[PSW_CY];
      cmp_r <= PSW_RST[PSW_CMP];
      bcd_r <= PSW_RST[PSW_BCD];
    end else begin
      if (PSW_WR) begin
        z_r <= PSW_WDATA[PSW_Z];
        cy_r <= PSW_WDATA[PSW_CY];
        cmp_r <= PSW_WDATA[PSW_CMP];
        bcd_r <= PSW_WDATA[PSW_BCD];
      end
      if (is_exec && is_arith) begin
        cy_r <= ar_res[4];
        if (cmp_r) begin
          z_r <= z_r & (ar_res[3:0] == NIB_ZERO);
        end else begin
          z_r <= (ar_res[3:0] == NIB_ZERO);
        end
      end
      if (is_exec && is_rot) begin
        cy_r <= tmp_a_r[0];
      end
      if (is_exec && is_bit) begin
        cmp_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // Result write and completion
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wr_en_r <= 1'b0;
      wr_data_r <= NIB_ZERO;
      done_r <= 1'b0;
      skip_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt == ST_EXEC);
      done_r <= is_exec;
      skip_r <= is_exec && (is_bit || is_cmpe) && skip_nxt;
      wr_en_r <= is_exec && ((is_arith && !cmp_r) || is_logic || is_rot);
      if (is_exec) begin
        if (is_arith) begin
          wr_data_r <= ar_res[3:0];
        end else if (is_rot) begin
          wr_data_r <= {cy_r, tmp_a_r[3:1]};
        end else if (is_logic) begin
          wr_data_r <= log_res;
        end
      end
    end
  end

  // Output drive
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign WR_EN = wr_en_r;
  assign WR_ADDR = addr_r;
  assign WR_DATA = wr_data_r;
  assign SKIP = skip_r;
  assign PSW_OUT = {bcd_r, cmp_r, cy_r, z_r};

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_accept;
    START && state_r == ST_IDLE;
  endsequence

  sequence s_run;
    s_accept ##1 is_exec;
  endsequence

  chk_done_timing: assert property (s_run |=> DONE && !BUSY)
    else $error("done not one cycle after execute");

  chk_dec_add_low: assert property (is_exec && bcd_r && !is_sub && is_arith &&
      bin_sum >= DEC_TEN && bin_sum < DEC_TWENTY |=> PSW_OUT[PSW_CY] &&
      WR_DATA == 4'($past(bin_sum) - DEC_TEN))
    else $error("decimal add 10..19 wrong");

  chk_dec_add_high: assert property (is_exec && bcd_r && !is_sub && is_arith &&
      bin_sum >= DEC_TWENTY |=> PSW_OUT[PSW_CY] && WR_DATA >= 4'ha)
    else $error("decimal add 20..31 wrong");

  chk_dec_sub_neg: assert property (is_exec && bcd_r && is_arith && is_sub &&
      bin_diff >= DEC_NEG_TEN |=> PSW_OUT[PSW_CY] && WR_DATA <= 4'h9)
    else $error("decimal borrow -10..-1 wrong");

  chk_dec_sub_out: assert property (is_exec && bcd_r && is_arith && is_sub &&
      bin_diff > DEC_NINE && bin_diff < DEC_NEG_TEN
      |=> PSW_OUT[PSW_CY] && WR_DATA[3:2] == 2'b11)
    else $error("decimal out of range wrong");

  chk_bin_result: assert property (is_exec && !bcd_r && is_arith |=>
      WR_DATA == $past(bin_res[3:0]) && PSW_OUT[PSW_CY] == $past(bin_res[4]))
    else $error("binary result or carry wrong");

  chk_cmp_nowrite: assert property (is_exec && is_arith |=> WR_EN == !$past(cmp_r))
    else $error("compare-only write gating wrong");

  chk_cmp_zero_hold: assert property (is_exec && is_arith && cmp_r &&
      ar_res[3:0] == NIB_ZERO |=> PSW_OUT[PSW_Z] == $past(z_r))
    else $error("zero flag not held");

  chk_rotate_flags: assert property (is_exec && is_rot |=>
      PSW_OUT[PSW_CY] == $past(tmp_a_r[0]) && WR_DATA[3] == $past(cy_r) && WR_EN)
    else $error("rotate through carry wrong");

  chk_bit_clear_cmp: assert property (is_exec && is_bit |=> !PSW_OUT[PSW_CMP])
    else $error("bit evaluation kept compare-only");

  chk_eval_nowrite: assert property (is_exec && (is_bit || is_cmpe) |=> !WR_EN)
    else $error("evaluation wrote a result");

  chk_logic_flags: assert property (is_exec && is_logic && !PSW_WR |=>
      $stable(PSW_OUT) && WR_EN)
    else $error("logical changed flags");

  // Accepted request with the immediate as second source
  sequence s_take_imm;
    s_accept ##0 (USE_IMM && OPCODE != OPC_ROTATE_RIGHT_THRU_CARRY);
  endsequence

  // Accepted rotate request, which must leave temp B alone
  sequence s_take_rot;
    s_accept ##0 (OPCODE == OPC_ROTATE_RIGHT_THRU_CARRY);
  endsequence

  // Busy and operand capture on the accepting edge
  chk_busy_pulse: assert property (s_accept |=> BUSY && !DONE)
    else $error("busy not raised after accept");

  chk_operand_a: assert property (s_accept |=> tmp_a_r == $past(FIRST_DATA))
    else $error("first operand not latched");

  chk_wr_addr_latch: assert property (s_accept |=> WR_ADDR == $past(FIRST_ADDR))
    else $error("result location not latched");

  chk_imm_select: assert property (s_take_imm |=> tmp_b_r == $past(IMM_NIBBLE))
    else $error("immediate not taken as second operand");

  chk_rot_keeps_b: assert property (s_take_rot |=> $stable(tmp_b_r))
    else $error("rotate loaded a second operand");

  // Results in the low decimal ranges pass through unchanged
  chk_dec_add_pass: assert property (is_exec && bcd_r && is_arith && !is_sub &&
      bin_sum <= DEC_NINE |=> !PSW_OUT[PSW_CY] && WR_DATA == $past(bin_sum[3:0]))
    else $error("decimal add 0..9 wrong");

  chk_dec_sub_pass: assert property (is_exec && bcd_r && is_arith && is_sub &&
      !bin_diff[4] && bin_diff <= DEC_NINE
      |=> !PSW_OUT[PSW_CY] && WR_DATA == $past(bin_diff[3:0]))
    else $error("decimal subtract 0..9 wrong");

  // Zero flag follows the nibble when results are stored
  chk_zero_store: assert property (is_exec && is_arith && !cmp_r |=>
      PSW_OUT[PSW_Z] == (WR_DATA == NIB_ZERO))
    else $error("zero flag does not follow result");

  // Skip only comes from evaluations
  chk_skip_equal: assert property (is_exec && opc_r == OPC_SKE |=>
      SKIP == ($past(tmp_a_r) == $past(tmp_b_r)))
    else $error("equal evaluation skip wrong");

  chk_no_skip_other: assert property (is_exec && !is_bit && !is_cmpe |=> !SKIP)
    else $error("skip raised by a non-evaluation");
endmodule : nibble_alu_bcd_binary

// file: nibble_mem_model.sv
// Behavioural register file and data memory on the far side of the nibble ALU
`timescale 1ns/1ns
module nibble_mem_model (
  input wire logic clk, // Core clock
  input wire logic wr_en, // Result write strobe
  input wire logic [nibble_alu_pkg::ADDR_W-1:0] wr_addr, // Result location
  input wire logic [nibble_alu_pkg::NIB_W-1:0] wr_data, // Result nibble
  input wire logic pl_en, // Bench preload strobe
  input wire logic [nibble_alu_pkg::ADDR_W-1:0] pl_addr, // Preload location
  input wire logic [nibble_alu_pkg::NIB_W-1:0] pl_data, // Preload nibble
  input wire logic [nibble_alu_pkg::ADDR_W-1:0] rd_addr, // Operand location
  output logic [nibble_alu_pkg::NIB_W-1:0] rd_data // Operand nibble
);
  import nibble_alu_pkg::*;
  logic [NIB_W-1:0] mem_r [2**ADDR_W];
  // ==========================================
  // Storage
  // Result write wins over a preload in the same cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end else if (pl_en) begin
      mem_r[pl_addr] <= pl_data;
    end
  end
  // Operand read is combinational, as the sequencer presents it with the request
  assign rd_data = mem_r[rd_addr];
endmodule : nibble_mem_model

// file: nibble_alu_bcd_binary_bench.sv
// Self-checking bench for the nibble ALU with a memory model on its far side
`timescale 1ns/1ns
module nibble_alu_bcd_binary_bench;
  import nibble_alu_pkg::*;
  // Row fields, one nibble each: op psw a b imm wr data psw_exp skip
  typedef logic [35:0] row_t;
  logic clk_sys = 1'b0, srst = 1'b1, start = 1'b0, use_imm = 1'b0, psw_wr = 1'b0, pl_en = 1'b0;
  logic busy, done, wr_en, skip;
  logic [OPC_W-1:0] opcode = 4'h0;
  logic [ADDR_W-1:0] first_addr = 7'h00, pl_addr = 7'h00, wr_addr;
  logic [NIB_W-1:0] mem_data = 4'h0, imm_nibble = 4'h0, pl_data = 4'h0, first_data, wr_data;
  logic [PSW_W-1:0] psw_wdata = 4'h0, psw_out;
  int miscompares = 0;
  int tests_run = 0;
  row_t rows [30];
  nibble_alu_bcd_binary u_dut (.CLK_SYS(clk_sys), .SRST(srst), .START(start), .OPCODE(opcode),
    .USE_IMM(use_imm), .FIRST_ADDR(first_addr), .FIRST_DATA(first_data), .MEM_DATA(mem_data),
    .IMM_NIBBLE(imm_nibble), .PSW_WR(psw_wr), .PSW_WDATA(psw_wdata), .BUSY(busy), .DONE(done),
    .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .SKIP(skip), .PSW_OUT(psw_out));
  nibble_mem_model u_mem (.clk(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .pl_en(pl_en), .pl_addr(pl_addr), .pl_data(pl_data), .rd_addr(first_addr),
    .rd_data(first_data));
  // ==========================================
  // Clock
  always #4 clk_sys = ~clk_sys;
  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  // Loads one location and the status word in one cycle
  task automatic pre(input logic [6:0] a, input logic [3:0] d, input logic [3:0] p);
    pl_en = 1'b1;
    pl_addr = a;
    pl_data = d;
    psw_wr = 1'b1;
    psw_wdata = p;
    tick();
    pl_en = 1'b0;
    psw_wr = 1'b0;
  endtask : pre
  // Presents a request; the unused second source carries the inverse as a decoy
  task automatic req(input logic [3:0] op, input logic [6:0] a, input logic [3:0] b, input logic im);
    start = 1'b1;
    opcode = op;
    first_addr = a;
    use_imm = im;
    imm_nibble = im ? b : ~b;
    mem_data = im ? ~b : b;
  endtask : req
  task automatic reset_check();
    check("reset outputs", {busy, done, wr_en, skip, psw_out, wr_data, wr_addr}, 19'h0);
  endtask : reset_check
  task automatic run_row(input row_t r, input logic [6:0] a);
    pre(a, r[27:24], r[31:28]);
    req(r[35:32], a, r[23:20], r[16]);
    tick();
    start = 1'b0;
    check("busy", {busy, done}, 2'b10);
    tick();
    check("done", done, 1'b1);
    check("wr_en", wr_en, r[12]);
    check("skip", skip, r[0]);
    check("psw_out", psw_out, r[7:4]);
    if (r[12]) begin
      check("wr_data", wr_data, r[11:8]);
      check("wr_addr", wr_addr, a);
    end
    tick();
    check("memory", {done, first_data}, {1'b0, r[12] ? r[11:8] : r[27:24]});
  endtask : run_row
  // ==========================================
  // Watchdog
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial begin
    rows = '{36'h0_0_5_7_0_1_c_0_0, 36'h0_0_9_7_1_1_0_3_0, 36'h2_0_3_5_0_1_e_2_0,
      36'h1_2_7_8_1_1_0_3_0, 36'h3_2_5_4_0_1_0_1_0, 36'h0_8_9_9_0_1_8_a_0,
      36'h0_8_f_f_1_1_c_a_0, 36'h0_8_9_b_0_1_e_a_0, 36'h0_8_f_d_1_1_a_a_0,
      36'h0_8_5_5_0_1_0_b_0, 36'h2_8_3_7_1_1_6_a_0, 36'h2_8_f_3_0_1_e_a_0,
      36'h2_8_0_f_1_1_f_a_0, 36'h3_a_0_0_0_1_9_a_0, 36'h0_4_3_3_0_0_0_4_0,
      36'h2_5_4_4_1_0_0_5_0, 36'h0_5_1_1_0_0_0_4_0, 36'h0_d_9_9_1_0_0_e_0,
      36'h0_4_f_1_0_0_0_6_0, 36'h4_f_a_5_0_1_f_f_0, 36'h5_3_c_a_1_1_8_3_0,
      36'h6_8_f_5_0_1_a_8_0, 36'h7_f_b_3_1_0_0_b_1, 36'h7_4_4_3_0_0_0_0_0,
      36'h8_6_4_3_1_0_0_2_1, 36'h9_4_5_5_0_0_0_4_1, 36'ha_0_5_5_1_0_0_0_0,
      36'ha_4_5_6_0_0_0_4_1, 36'hb_2_5_0_0_1_a_2_0, 36'hb_d_4_0_0_1_2_d_0};
    repeat (3) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    reset_check();
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      run_row(rows[i], 7'(i));
      $display("test row %0d done", i);
    end
    // Back-to-back requests, the carry of the first feeding the second
    pre(7'h64, 4'h9, 4'h0);
    pre(7'h65, 4'h2, 4'h0);
    req(4'h0, 7'h64, 4'h8, 1'b0);
    tick();
    start = 1'b0;
    tick();
    check("first result", {done, psw_out, wr_data}, 9'h121);
    req(4'h1, 7'h65, 4'h3, 1'b0);
    tick();
    // A request in the busy cycle must be dropped
    req(4'h2, 7'h64, 4'h1, 1'b1);
    check("busy b2b", busy, 1'b1);
    tick();
    start = 1'b0;
    check("second result", {done, wr_data, wr_addr}, {1'b1, 4'h6, 7'h65});
    tick();
    check("refused", {done, busy, first_data}, 6'h01);
    $display("test back_to_back done");
    // Reset in the busy cycle clears everything, then a request is served
    pre(7'h66, 4'h7, 4'hf);
    req(4'h0, 7'h66, 4'h7, 1'b0);
    tick();
    start = 1'b0;
    srst = 1'b1;
    tick();
    srst = 1'b0;
    reset_check();
    run_row(rows[0], 7'h67);
    $display("test midrun_reset done");
    test_done();
  end
endmodule : nibble_alu_bcd_binary_bench
